// >>> test_v6flt_matcher.sv
// Purpose: Self-checking bench for the filter matcher
// Assumes: Defaults of 16 entries
// Notes: Frames wait for the previous verdict
`timescale 1ns/1ps
`include "v6flt_consts.svh"
module test_v6flt_matcher;
	import v6flt_pkg::*;
	localparam logic [127:0] A = {8{16'h2001}};
	localparam logic [127:0] B = {8{16'h00fe}};
	logic i_sys_clk = 0, i_resetn = 0, i_load = 0, i_clear = 0, i_send = 0, fv, o_busy, o_done;
	logic o_hit, o_forward, o_learn, o_drop, o_conflict;
	logic [3:0] i_load_idx = '0, o_hit_idx;
	logic [15:0] o_installed;
	v6flt_entry_s e = '0;
	v6flt_hdr_s h = '0, fh;
	int fail_count = 0, samples_checked = 0, cyc = 0;
	v6flt_matcher #(.ENTRIES(16), .IDXW(4)) dut_u (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.i_load(i_load), .i_load_idx(i_load_idx), .i_load_entry(e), .i_clear_idx(i_clear),
		.i_frame_valid(fv), .i_frame_hdr(fh), .o_busy(o_busy), .o_done(o_done), .o_hit(o_hit),
		.o_forward(o_forward), .o_learn(o_learn), .o_drop(o_drop), .o_hit_idx(o_hit_idx),
		.o_conflict(o_conflict), .o_installed(o_installed));
	v6flt_port port_u (.i_sys_clk(i_sys_clk), .i_send(i_send), .i_hdr(h), .o_frame_valid(fv), .o_frame_hdr(fh));
	//----------------------------------------
	// Clock, timeout and access tasks
	//----------------------------------------
	initial forever #2 i_sys_clk = ~i_sys_clk;
	// Cuts a hang well past the expected run
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			summarize();
		end
	end
	task summarize;
		$display("Compared %0d, mismatched %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, g, x);
		end
	endtask
	task load(input logic [3:0] ix, input v6flt_entry_s en, input logic cf);
		@(posedge i_sys_clk);
		i_load <= 1'b1;
		i_load_idx <= ix;
		e <= en;
		@(posedge i_sys_clk);
		i_load <= 1'b0;
		// Conflict passes through a status flop before the port shows it
		@(posedge i_sys_clk);
		#1 chk(o_conflict, cf);
	endtask
	task frame(input v6flt_hdr_s hv, input logic ht, input logic dr, input logic [3:0] ix);
		int n;
		@(posedge i_sys_clk);
		i_send <= 1'b1;
		h <= hv;
		@(posedge i_sys_clk);
		i_send <= 1'b0;
		@(posedge i_sys_clk);
		#1 chk(o_busy, 1'b1);
		for (n = 0; n < 40 && o_done !== 1'b1; n++) begin
			@(posedge i_sys_clk);
			#1;
		end
		chk(o_done, 1'b1);
		chk(o_busy, 1'b0);
		chk({o_hit, o_drop, o_forward, o_learn, o_hit_idx}, {ht, dr, ~dr, ~dr, ix});
	endtask
	//----------------------------------------
	// Test sequence
	//----------------------------------------
	initial begin
		v6flt_entry_s en;
		repeat (12) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		// Slot 0 denies protocol 6 with destination port 100..200
		en = '0;
		en.action = `V6FLT_ACT_DENY;
		en.proto_en = 1'b1;
		en.proto = 8'h06;
		en.dport_mode = `V6FLT_PORT_RANGE;
		en.dport_lo = 16'h0064;
		en.dport_hi = 16'h00c8;
		load(4'h0, en, 1'b0);
		en = '0;
		en.action = `V6FLT_ACT_DENY;
		en.src_en = 1'b1;
		en.src_addr = A;
		en.src_pfx = 8'h40;
		load(4'h1, en, 1'b0);
		en = '0;
		en.dst_en = 1'b1;
		en.dst_addr = B;
		en.dst_pfx = 8'h80;
		en.dport_mode = `V6FLT_PORT_SINGLE;
		en.dport_lo = 16'h0050;
		load(4'h2, en, 1'b0);
		en = '0;
		en.action = `V6FLT_ACT_DENY;
		en.flag_crit = 12'h0804;
		load(4'h3, en, 1'b0);
		en.flag_crit = 12'h0000;
		en.sport_mode = `V6FLT_PORT_SINGLE;
		en.sport_lo = 16'h0007;
		load(4'h4, en, 1'b0);
		// Inverted range cannot be installed
		en.sport_mode = `V6FLT_PORT_RANGE;
		en.sport_lo = 16'h0009;
		en.sport_hi = 16'h0008;
		load(4'h5, en, 1'b1);
		chk(o_installed, 16'h001f);
		frame('{8'h06, '0, '0, 16'h0001, 16'h00c8, 1'b1, 6'h00}, 1, 1, 4'h0);
		frame('{8'h06, '0, '0, 16'h0001, 16'h00c9, 1'b1, 6'h00}, 0, 0, 4'hf);
		frame('{8'h11, {A[127:64], ~A[63:0]}, '0, 16'h0001, 16'h0096, 1'b0, 6'h00}, 1, 1, 4'h1);
		frame('{8'h06, '0, B, 16'h0001, 16'h0050, 1'b1, 6'h00}, 1, 0, 4'h2);
		frame('{8'h06, '0, B ^ 128'h1, 16'h0001, 16'h0050, 1'b1, 6'h02}, 1, 1, 4'h3);
		frame('{8'h06, '0, '0, 16'h0007, 16'h0000, 1'b1, 6'h22}, 1, 1, 4'h4);
		// Slot 5 now takes a legal source port range 9..11
		en = '0;
		en.action = `V6FLT_ACT_DENY;
		en.sport_mode = `V6FLT_PORT_RANGE;
		en.sport_lo = 16'h0009;
		en.sport_hi = 16'h000b;
		load(4'h5, en, 1'b0);
		frame('{8'h06, '0, '0, 16'h000b, 16'h0000, 1'b1, 6'h00}, 1, 1, 4'h5);
		frame('{8'h06, '0, '0, 16'h000c, 16'h0000, 1'b1, 6'h00}, 0, 0, 4'hf);
		// Each flag in set and unset modes on slot 3
		for (int b = 0; b < 6; b++) begin
			en = '0;
			en.action = `V6FLT_ACT_DENY;
			en.flag_crit = 12'h001 << (2 * b);
			load(4'h3, en, 1'b0);
			frame('{8'h06, '0, '0, 16'h0001, 16'h0000, 1'b1, 6'h01 << b}, 1, 1, 4'h3);
			frame('{8'h06, '0, '0, 16'h0001, 16'h0000, 1'b1, 6'h00}, 0, 0, 4'hf);
			en.flag_crit = 12'h002 << (2 * b);
			load(4'h3, en, 1'b0);
			frame('{8'h06, '0, '0, 16'h0001, 16'h0000, 1'b1, 6'h01 << b}, 0, 0, 4'hf);
			frame('{8'h06, '0, '0, 16'h0001, 16'h0000, 1'b1, 6'h00}, 1, 1, 4'h3);
		end
		// Uninstalling slot 3 lets the frame fall through to a miss
		@(posedge i_sys_clk);
		i_clear <= 1'b1;
		i_load_idx <= 4'h3;
		@(posedge i_sys_clk);
		i_clear <= 1'b0;
		@(posedge i_sys_clk);
		#1 chk(o_installed, 16'h0037);
		frame('{8'h06, '0, '0, 16'h0001, 16'h0000, 1'b1, 6'h00}, 0, 0, 4'hf);
		summarize();
	end
endmodule

// >>> v6flt_chk.sv
// Purpose: Port checker for the filter matcher
// Assumes: Bound to every matcher instance
// Notes: Most verdict bits are judged at the done strobe; drop-implies-hit and hold are checked every cycle
`timescale 1ns/1ps
module v6flt_chk #(
	parameter int ENTRIES = 16,
	parameter int IDXW = 4
) (
	// Inputs watched
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_load,
	input wire logic i_clear_idx,
	input wire v6flt_pkg::v6flt_entry_s i_load_entry,
	// Outputs watched
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_hit,
	input wire logic o_forward,
	input wire logic o_learn,
	input wire logic o_drop,
	input wire logic [IDXW-1:0] o_hit_idx,
	input wire logic o_conflict,
	input wire logic [ENTRIES-1:0] o_installed
);
	import v6flt_pkg::*;
	localparam int LAT = ENTRIES;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	// A scan may not hang past the last entry
	property p_scan_end; $rose(o_busy) |-> ##[1:LAT] o_done; endproperty
	a_scan_end: assert property (p_scan_end) else $error("scan overran");
	property p_done_pulse; o_done |=> !o_done; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done too long");
	property p_fwd_drop; o_done |-> o_forward != o_drop; endproperty
	a_fwd_drop: assert property (p_fwd_drop) else $error("forward and drop agree");
	property p_learn; o_done |-> o_learn == o_forward; endproperty
	a_learn: assert property (p_learn) else $error("learn differs from forward");
	property p_drop_hit; o_drop |-> o_hit; endproperty
	a_drop_hit: assert property (p_drop_hit) else $error("drop without hit");
	property p_miss_idx; o_done && !o_hit |-> o_hit_idx == ENTRIES - 1; endproperty
	a_miss_idx: assert property (p_miss_idx) else $error("bad index on miss");
	// Verdict must not wander between strobes
	property p_hold; $changed({o_hit, o_drop, o_forward, o_hit_idx}) |-> o_done; endproperty
	a_hold: assert property (p_hold) else $error("verdict moved");
	property p_bad_range;
		i_load && i_load_entry.sport_mode == 2'h2 && i_load_entry.sport_lo > i_load_entry.sport_hi
		|-> ##2 o_conflict;
	endproperty
	a_bad_range: assert property (p_bad_range) else $error("no conflict");
	// Map reaches the port two edges after the load or clear is taken
	property p_map; $changed(o_installed) |-> $past(i_load, 2) || $past(i_clear_idx, 2); endproperty
	a_map: assert property (p_map) else $error("map moved alone");
endmodule
bind v6flt_matcher v6flt_chk #(.ENTRIES(ENTRIES), .IDXW(IDXW)) chk_u (.i_sys_clk(i_sys_clk),
	.i_resetn(i_resetn), .i_load(i_load), .i_clear_idx(i_clear_idx), .i_load_entry(i_load_entry),
	.o_busy(o_busy), .o_done(o_done), .o_hit(o_hit), .o_forward(o_forward), .o_learn(o_learn),
	.o_drop(o_drop), .o_hit_idx(o_hit_idx), .o_conflict(o_conflict), .o_installed(o_installed));

// >>> v6flt_consts.svh
// Purpose: Constants for the IPv6 frame filter entry matcher
// Assumes: One clock, asynchronous active-low reset
// Notes: Field codes and reset values shared by design and tests
//
// Overview of operation
// [RQ1] Permit match forwards the frame and allows source learning.
// [RQ2] Deny match discards the frame, no forwarding.
// [RQ3] Protocol criterion is any, or equality with one protocol number.
// [RQ4] Source address criterion is any or user defined.
// [RQ5] User defined source address is 128 bits, compared for equality.
// [RQ6] Source prefix length limits compared leading bits.
// [RQ7] Destination address criterion is any or user defined.
// [RQ8] User defined destination address must equal stored 128-bit value.
// [RQ9] Destination prefix length limits compared leading bits.
// [RQ10] Source port any means don't-care.
// [RQ11] Source port single mode needs exact 16-bit equality.
// [RQ12] Source port range mode needs port within bounds.
// [RQ13] Destination port any means don't-care.
// [RQ14] Destination port single mode needs exact equality.
// [RQ15] Destination port range mode needs port within bounds.
// [RQ16] URG flag criterion: set, unset or don't-care.
// [RQ17] ACK flag criterion: set, unset or don't-care.
// [RQ18] PSH flag criterion: set, unset or don't-care.
// [RQ19] RST flag criterion: set, unset or don't-care.
// [RQ20] Entry that cannot be installed is reported as in conflict.
// [RQ21] SYN flag criterion: set, unset or don't-care.
// [RQ22] FIN flag criterion: set, unset or don't-care.
// [RQ23] Entries checked in ascending sequence; first full match decides.
// [RQ24] Match needs every non-wildcard criterion satisfied together.
`ifndef V6FLT_CONSTS_SVH
`define V6FLT_CONSTS_SVH
// Port criterion modes
`define V6FLT_PORT_ANY 2'h0
`define V6FLT_PORT_SINGLE 2'h1
`define V6FLT_PORT_RANGE 2'h2
// Flag criterion settings
`define V6FLT_FLAG_DC 2'h0
`define V6FLT_FLAG_SET 2'h1
`define V6FLT_FLAG_UNSET 2'h2
// Flag bit positions within the six-bit flag vector
`define V6FLT_FIN_BIT 0
`define V6FLT_SYN_BIT 1
`define V6FLT_RST_BIT 2
`define V6FLT_PSH_BIT 3
`define V6FLT_ACK_BIT 4
`define V6FLT_URG_BIT 5
// Action codes
`define V6FLT_ACT_PERMIT 1'h0
`define V6FLT_ACT_DENY 1'h1
// Reset value and prefix length limit
`define V6FLT_RST_VEC 16'h0000
`define V6FLT_PFX_MAX 8'h80
`endif

// >>> v6flt_matcher.sv
// Purpose: Walks the filter list for each frame and gives the verdict
// Assumes: Header fields arrive parsed, synchronous to i_sys_clk
// Notes: One entry compared per clock, so a verdict takes up to N+1 cycles
`timescale 1ns/1ps
`include "v6flt_consts.svh"
module v6flt_matcher #(
	parameter int ENTRIES = 16,
	parameter int IDXW = 4
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// Entry load port
	input wire logic i_load,
	input wire logic [IDXW-1:0] i_load_idx,
	input wire v6flt_pkg::v6flt_entry_s i_load_entry,
	input wire logic i_clear_idx,
	// Frame request
	input wire logic i_frame_valid,
	input wire v6flt_pkg::v6flt_hdr_s i_frame_hdr,
	// Verdict
	output logic o_busy,
	output logic o_done,
	output logic o_hit,
	output logic o_forward,
	output logic o_learn,
	output logic o_drop,
	output logic [IDXW-1:0] o_hit_idx,
	// Load status
	output logic o_conflict,
	output logic [ENTRIES-1:0] o_installed
);
	import v6flt_pkg::*;

	// Refuse a table that the index cannot address
	if (ENTRIES < 1 || (1 << IDXW) < ENTRIES) begin
		$error("ENTRIES does not fit IDXW");
	end

	//----------------------------------------------------------
	// Functions
	//----------------------------------------------------------
	// Leading-bit mask for a prefix length; lengths past 128 clamp
	function automatic logic [127:0] pfx_mask(input logic [7:0] len);
		logic [127:0] m;
		m = '1;
		if (len < `V6FLT_PFX_MAX) begin
			m = ~(128'(m) >> len);
		end
		return m;
	endfunction

	// Address check under prefix, exact equality on the kept bits
	function automatic logic addr_ok(input logic en, input logic [127:0] want,
		input logic [127:0] got, input logic [7:0] len);
		return !en || (((want ^ got) & pfx_mask(len)) == 128'h0);
	endfunction

	// Port check: any, single value or inclusive range
	function automatic logic port_ok(input logic [1:0] mode, input logic [15:0] lo,
		input logic [15:0] hi, input logic [15:0] p);
		logic r;
		r = 1'b0;
		if (mode == `V6FLT_PORT_ANY) begin
			r = 1'b1;
		end else if (mode == `V6FLT_PORT_SINGLE) begin
			r = (p == lo);
		end else if (mode == `V6FLT_PORT_RANGE) begin
			r = (p >= lo) && (p <= hi);
		end
		return r;
	endfunction

	// One flag criterion against one TCP flag bit
	function automatic logic flag_ok(input logic [1:0] crit, input logic tcp, input logic bit_v);
		logic r;
		r = 1'b1;
		if (crit == `V6FLT_FLAG_SET) begin
			r = tcp && bit_v;
		end else if (crit == `V6FLT_FLAG_UNSET) begin
			r = !(tcp && bit_v);
		end
		return r;
	endfunction

	// Entry legality: a bad mode or inverted range cannot be installed
	function automatic logic entry_fits(input v6flt_entry_s e);
		logic r;
		integer k;
		r = (e.sport_mode != 2'h3) && (e.dport_mode != 2'h3);
		if (e.sport_mode == `V6FLT_PORT_RANGE && e.sport_lo > e.sport_hi) begin
			r = 1'b0;
		end
		if (e.dport_mode == `V6FLT_PORT_RANGE && e.dport_lo > e.dport_hi) begin
			r = 1'b0;
		end
		if ((e.src_en && e.src_pfx > `V6FLT_PFX_MAX) || (e.dst_en && e.dst_pfx > `V6FLT_PFX_MAX)) begin
			r = 1'b0;
		end
		for (k = 0; k < 6; k++) begin
			if (e.flag_crit[2*k +: 2] == 2'h3) begin
				r = 1'b0;
			end
		end
		return r;
	endfunction

	//----------------------------------------------------------
	// Entry store
	//----------------------------------------------------------
	v6flt_entry_s table_mem [ENTRIES];
	logic [ENTRIES-1:0] inst_reg;
	logic conflict_reg;
	logic load_in_range;

	assign load_in_range = (32'(i_load_idx) < ENTRIES);

	// Entry words hold no control state, so they carry no reset
	always_ff @(posedge i_sys_clk) begin
		if (i_load && load_in_range && entry_fits(i_load_entry)) begin
			table_mem[i_load_idx] <= i_load_entry;
		end
	end

	// Installed map; a rejected load leaves the slot empty and flags conflict
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			inst_reg <= '0;
			conflict_reg <= 1'b0;
		end else begin
			if (i_clear_idx && 32'(i_load_idx) < ENTRIES) begin
				inst_reg[i_load_idx] <= 1'b0;
			end
			if (i_load) begin
				conflict_reg <= !(load_in_range && entry_fits(i_load_entry)); // RQ20
				if (load_in_range) begin
					inst_reg[i_load_idx] <= entry_fits(i_load_entry); // RQ20
				end
			end
		end
	end

	//----------------------------------------------------------
	// Scan engine
	//----------------------------------------------------------
	v6flt_state_e state_reg;
	v6flt_hdr_s hdr_reg;
	logic [IDXW-1:0] idx_reg;
	logic entry_match;
	v6flt_entry_s cur;
	logic last_idx;

	assign cur = table_mem[idx_reg];
	assign last_idx = (32'(idx_reg) == ENTRIES - 1);

	// Full entry match, every enabled criterion at once
	always_comb begin
		entry_match = inst_reg[idx_reg]
			&& (!cur.proto_en || cur.proto == hdr_reg.proto) // RQ3
			&& addr_ok(cur.src_en, cur.src_addr, hdr_reg.src_addr, cur.src_pfx) // RQ4 RQ5 RQ6
			&& addr_ok(cur.dst_en, cur.dst_addr, hdr_reg.dst_addr, cur.dst_pfx) // RQ7 RQ8 RQ9
			&& port_ok(cur.sport_mode, cur.sport_lo, cur.sport_hi, hdr_reg.sport) // RQ10 RQ11 RQ12
			&& port_ok(cur.dport_mode, cur.dport_lo, cur.dport_hi, hdr_reg.dport) // RQ13 RQ14 RQ15
			&& flag_ok(cur.flag_crit[2*`V6FLT_URG_BIT +: 2], hdr_reg.is_tcp, hdr_reg.flags[`V6FLT_URG_BIT]) // RQ16
			&& flag_ok(cur.flag_crit[2*`V6FLT_ACK_BIT +: 2], hdr_reg.is_tcp, hdr_reg.flags[`V6FLT_ACK_BIT]) // RQ17
			&& flag_ok(cur.flag_crit[2*`V6FLT_PSH_BIT +: 2], hdr_reg.is_tcp, hdr_reg.flags[`V6FLT_PSH_BIT]) // RQ18
			&& flag_ok(cur.flag_crit[2*`V6FLT_RST_BIT +: 2], hdr_reg.is_tcp, hdr_reg.flags[`V6FLT_RST_BIT]) // RQ19
			&& flag_ok(cur.flag_crit[2*`V6FLT_SYN_BIT +: 2], hdr_reg.is_tcp, hdr_reg.flags[`V6FLT_SYN_BIT]) // RQ21
			&& flag_ok(cur.flag_crit[2*`V6FLT_FIN_BIT +: 2], hdr_reg.is_tcp, hdr_reg.flags[`V6FLT_FIN_BIT]); // RQ22
	end // RQ24

	// Sequential walk in ascending index; first hit stops the walk
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= V6FLT_IDLE;
			idx_reg <= '0;
			hdr_reg <= '0;
		end else begin
			case (state_reg)
				V6FLT_IDLE: begin
					if (i_frame_valid) begin
						hdr_reg <= i_frame_hdr;
						idx_reg <= '0;
						state_reg <= V6FLT_SCAN;
					end
				end
				V6FLT_SCAN: begin
					if (entry_match || last_idx) begin
						state_reg <= V6FLT_IDLE; // RQ23
					end else begin
						idx_reg <= idx_reg + 1'b1; // RQ23
					end
				end
				default: begin
					state_reg <= V6FLT_IDLE;
				end
			endcase
		end
	end

	//----------------------------------------------------------
	// Verdict outputs
	//----------------------------------------------------------
	// No entry hit means forward: a list only blocks what it names
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_done <= 1'b0;
			o_hit <= 1'b0;
			o_forward <= 1'b0;
			o_learn <= 1'b0;
			o_drop <= 1'b0;
			o_hit_idx <= '0;
		end else begin
			o_done <= 1'b0;
			if (state_reg == V6FLT_SCAN && (entry_match || last_idx)) begin
				o_done <= 1'b1;
				o_hit <= entry_match;
				o_hit_idx <= idx_reg;
				o_drop <= entry_match && cur.action == `V6FLT_ACT_DENY; // RQ2
				o_forward <= !(entry_match && cur.action == `V6FLT_ACT_DENY); // RQ1 RQ2
				o_learn <= !(entry_match && cur.action == `V6FLT_ACT_DENY); // RQ1
			end
		end
	end

	// Conflict and map outputs mirror registers; busy follows the scan state
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_busy <= 1'b0;
			o_conflict <= 1'b0;
			o_installed <= '0;
		end else begin
			o_busy <= (state_reg == V6FLT_IDLE) ? i_frame_valid : !(entry_match || last_idx);
			o_conflict <= conflict_reg;
			o_installed <= inst_reg;
		end
	end
endmodule

// >>> v6flt_pkg.sv
// Purpose: Types of the IPv6 frame filter entry matcher
// Assumes: Constants come from v6flt_consts.svh
// Notes: Entry and frame header travel as packed structs
package v6flt_pkg;
	// One filter entry as software loads it
	typedef struct packed {
		logic action;
		logic proto_en;
		logic [7:0] proto;
		logic src_en;
		logic [127:0] src_addr;
		logic [7:0] src_pfx;
		logic dst_en;
		logic [127:0] dst_addr;
		logic [7:0] dst_pfx;
		logic [1:0] sport_mode;
		logic [15:0] sport_lo;
		logic [15:0] sport_hi;
		logic [1:0] dport_mode;
		logic [15:0] dport_lo;
		logic [15:0] dport_hi;
		logic [11:0] flag_crit;
	} v6flt_entry_s;
	// Parsed header fields of one received frame
	typedef struct packed {
		logic [7:0] proto;
		logic [127:0] src_addr;
		logic [127:0] dst_addr;
		logic [15:0] sport;
		logic [15:0] dport;
		logic is_tcp;
		logic [5:0] flags;
	} v6flt_hdr_s;
	// Matcher states
	typedef enum logic [1:0] {
		V6FLT_IDLE = 2'b01,
		V6FLT_SCAN = 2'b10
	} v6flt_state_e;
endpackage

// >>> v6flt_port.sv
// Purpose: Switch port model handing parsed headers to the matcher
// Assumes: Sends only while the matcher idles
// Notes: Released header flips to its inverse each cycle so stale fields never match
`timescale 1ns/1ps
module v6flt_port (
	// Clock and test side
	input wire logic i_sys_clk,
	input wire logic i_send,
	input wire v6flt_pkg::v6flt_hdr_s i_hdr,
	// Matcher side
	output logic o_frame_valid,
	output v6flt_pkg::v6flt_hdr_s o_frame_hdr
);
	import v6flt_pkg::*;
	// One-cycle strobe per frame
	initial o_frame_valid = 1'b0;
	initial o_frame_hdr = '0;
	always @(posedge i_sys_clk) begin
		o_frame_valid <= i_send;
		o_frame_hdr <= i_send ? i_hdr : ~o_frame_hdr;
	end
endmodule
